// [rtl/sacq_host.sv]
/*
 * Host capture controller: issues conversion-start pulses to the
 * converter and captures each result on the data-available edges.
 * Assumes the converter pins are already synchronous to core_clk_i.
 */
// Behaviour
// - The previous result is still held at data-available's falling edge.
// - The start strobe stays high 20 ns to 50 ns per request.
// - The start strobe stays low at least 20 ns between pulses.
// - The strobe may fall right after the data-available transition.
// - A new start may follow the data-available edge with no gap.
`default_nettype none
module sacq_host (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic continuous_i,
   input wire sacq_pkg::sacq_dev_pins_t dev_i,
   output logic encode_strobe_o,
   output logic busy_o,
   output logic sample_valid_o,
   output var sacq_pkg::sacq_sample_t sample_o,
   output logic prev_valid_o,
   output var sacq_pkg::sacq_sample_t prev_o
);
   import sacq_pkg::*;

   // ****************************************
   // Strobe sequencer
   // ****************************************
   sacq_state_t state_q, state_d;
   logic [1:0] cnt_q, cnt_d;
   logic enc_q, enc_d;
   logic busy_q, busy_d;

   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      enc_d = 1'b0;
      busy_d = busy_q;
      case (state_q)
         ST_IDLE: begin
            if (start_i || continuous_i) begin
               state_d = ST_HIGH;
               enc_d = 1'b1;
               cnt_d = 2'h1;
               busy_d = 1'b1;
            end else begin
               busy_d = 1'b0;
            end
         end
         ST_HIGH: begin
            if (int'(cnt_q) >= HIGH_MIN_CYC) begin
               // Falling here keeps the pulse inside the 20..50 ns window.
               state_d = ST_LOW;
               cnt_d = 2'h1;
            end else begin
               enc_d = 1'b1;
               cnt_d = cnt_q + 2'h1;
            end
         end
         ST_LOW: begin
            if (int'(cnt_q) >= LOW_MIN_CYC) begin
               state_d = ST_IDLE;
               cnt_d = HIGH_CNT_RST;
               if (continuous_i) begin
                  // Back-to-back request without waiting for the result.
                  state_d = ST_HIGH;
                  enc_d = 1'b1;
                  cnt_d = 2'h1;
               end
            end else begin
               cnt_d = cnt_q + 2'h1;
            end
         end
         default: begin
            state_d = ST_IDLE;
            cnt_d = HIGH_CNT_RST;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= ST_IDLE;
         cnt_q <= HIGH_CNT_RST;
         enc_q <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         enc_q <= enc_d;
         busy_q <= busy_d;
      end
   end

   assign encode_strobe_o = enc_q;
   assign busy_o = busy_q;

   // ****************************************
   // Result capture
   // ****************************************
   logic dav_q, dav_d;
   logic sval_q, sval_d;
   logic pval_q, pval_d;
   sacq_sample_t samp_q, samp_d, prev_q, prev_d;
   sacq_sample_t cur;

   always_comb begin
      cur.code = dev_i.bits;
      // Replacing the top bit by its complement gives twos complement.
      cur.code_twos = {dev_i.msb_inv, dev_i.bits[RESULT_W-2:0]};
      cur.overrange = dev_i.input_overrange_flag;
   end

   always_comb begin
      dav_d = dev_i.result_available_strobe;
      sval_d = 1'b0;
      pval_d = 1'b0;
      samp_d = samp_q;
      prev_d = prev_q;
      // Data is settled before the rising edge, so capture on it.
      if (dav_d && !dav_q) begin
         samp_d = cur;
         sval_d = 1'b1;
      end
      // Data still holds across the falling edge for the old result.
      if (!dav_d && dav_q) begin
         prev_d = cur;
         pval_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dav_q <= 1'b0;
         sval_q <= 1'b0;
         pval_q <= 1'b0;
         samp_q <= '0;
         prev_q <= '0;
      end else begin
         dav_q <= dav_d;
         sval_q <= sval_d;
         pval_q <= pval_d;
         samp_q <= samp_d;
         prev_q <= prev_d;
      end
   end

   assign sample_valid_o = sval_q;
   assign sample_o = samp_q;
   assign prev_valid_o = pval_q;
   assign prev_o = prev_q;

   // ****************************************
   // Assertions
   // ****************************************
   logic [2:0] hi_run_q, hi_run_d, lo_run_q, lo_run_d;

   // Both run counters saturate, so a long idle spell never wraps round
   // into a false short-gap report.
   always_comb begin
      hi_run_d = 3'h0;
      lo_run_d = 3'h0;
      if (enc_q) begin
         hi_run_d = (hi_run_q == 3'h7) ? hi_run_q : hi_run_q + 3'h1;
      end else begin
         lo_run_d = (lo_run_q == 3'h7) ? lo_run_q : lo_run_q + 3'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hi_run_q <= 3'h0;
         lo_run_q <= 3'h0;
      end else begin
         hi_run_q <= hi_run_d;
         lo_run_q <= lo_run_d;
      end
   end

   a_high_max_width: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      int'(hi_run_q) <= HIGH_MAX_CYC)
      else $error("start strobe high too long");
   a_high_min_width: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(enc_q) |-> int'(hi_run_q) >= HIGH_MIN_CYC)
      else $error("start strobe high too short");
   a_low_min_width: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(enc_q) |-> int'(lo_run_q) >= LOW_MIN_CYC)
      else $error("start strobe low too short");
   a_start_pulse: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == ST_IDLE && start_i) |=> enc_q && busy_q)
      else $error("start request gave no pulse");
   a_rise_capture: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $rose(dev_i.result_available_strobe) |=> sval_q
         && samp_q.code == $past(dev_i.bits))
      else $error("result not captured on rising edge");
   a_fall_capture: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      $fell(dev_i.result_available_strobe) |=> pval_q
         && prev_o.overrange == $past(dev_i.input_overrange_flag))
      else $error("previous result not captured on falling edge");
   a_twos_top: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      sval_q |-> samp_q.code_twos
         == {$past(dev_i.msb_inv), $past(dev_i.bits[RESULT_W-2:0])})
      else $error("twos word low bits differ");
   a_back_to_back: assert property (
      @(posedge core_clk_i) disable iff (!rst_n_i)
      (state_q == ST_LOW && continuous_i && int'(cnt_q) >= LOW_MIN_CYC)
      |=> enc_q)
      else $error("continuous mode left a gap");

   c_single: cover property (@(posedge core_clk_i) $rose(enc_q));
   c_sample: cover property (@(posedge core_clk_i) sval_q);
   c_prev: cover property (@(posedge core_clk_i) pval_q);
   c_overrange: cover property (@(posedge core_clk_i)
      sval_q && samp_q.overrange);
endmodule
`default_nettype wire

// [rtl/sacq_pkg.sv]
/*
 * Package of the host-side capture controller for a clockless 12-bit
 * sampling converter: timing constants, pin bundles and states.
 * Assumes a single 50 MHz core clock and device pins that are
 * synchronous to it.
 */
`default_nettype none
package sacq_pkg;
   localparam int CLK_PERIOD_NS = 20;
   // Start strobe high time, least and most, in ns.
   localparam int STROBE_HIGH_WIDTH_MIN_NS = 20;
   localparam int STROBE_HIGH_WIDTH_MAX_NS = 50;
   // Start strobe low time, least, in ns.
   localparam int STROBE_LOW_WIDTH_MIN_NS = 20;
   // Least times rounded up, longest times rounded down, at least one cycle.
   localparam int HIGH_MIN_CYC = (STROBE_HIGH_WIDTH_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int HIGH_MAX_CYC = (STROBE_HIGH_WIDTH_MAX_NS / CLK_PERIOD_NS < 1)
      ? 1 : STROBE_HIGH_WIDTH_MAX_NS / CLK_PERIOD_NS;
   localparam int LOW_MIN_CYC = (STROBE_LOW_WIDTH_MIN_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int RESULT_W = 12;
   localparam logic [1:0] HIGH_CNT_RST = 2'h0;

   // Pins returned by the converter.
   typedef struct packed {
      logic [RESULT_W-1:0] bits;   // bits[11] is the most significant bit
      logic msb_inv;
      logic input_overrange_flag;
      logic result_available_strobe;
   } sacq_dev_pins_t;

   // One captured sample handed to the user.
   typedef struct packed {
      logic [RESULT_W-1:0] code;
      logic [RESULT_W-1:0] code_twos;
      logic overrange;
   } sacq_sample_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HIGH = 3'b010,
      ST_LOW  = 3'b100
   } sacq_state_t;
endpackage
`default_nettype wire

// [tb/sacq_dev_model.sv]
/*
 * Behavioural model of the converter pins: one result per start pulse, a new pulse restarting the count.
 * Assumes it shares core_clk_i with the host controller.
 */
`default_nettype none
module sacq_dev_model #(parameter int CONV = 6) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic enc_i,
   input wire logic [11:0] val_i,
   input wire logic ovr_i,
   output var sacq_pkg::sacq_dev_pins_t pins_o
);
   import sacq_pkg::*;
   logic enc_q;
   logic [7:0] cnt_q;
   logic [11:0] hold_q;
   logic ovr_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         enc_q <= 1'b0;
         cnt_q <= 8'h0;
         hold_q <= 12'h0;
         ovr_q <= 1'b0;
         pins_o <= '0;
      end else begin
         enc_q <= enc_i;
         if (enc_i && !enc_q) begin
            cnt_q <= 8'h1;
            hold_q <= val_i;
            ovr_q <= ovr_i;
            pins_o.result_available_strobe <= 1'b0;
         end else if (cnt_q != 8'h0) begin
            cnt_q <= (cnt_q == CONV) ? 8'h0 : cnt_q + 8'h1;
            // Pins churn once the hold time has run out.
            if (cnt_q == 8'h2) begin
               pins_o.bits <= ~pins_o.bits;
               pins_o.msb_inv <= ~pins_o.msb_inv;
               pins_o.input_overrange_flag <= ~pins_o.input_overrange_flag;
            end
            if (cnt_q == CONV - 1) begin
               pins_o.bits <= hold_q;
               pins_o.msb_inv <= ~hold_q[11];
               pins_o.input_overrange_flag <= ovr_q;
            end
            if (cnt_q == CONV) begin
               pins_o.result_available_strobe <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
/*
 * Self-checking bench of the capture controller with a converter model.
 * Assumes the package and the host module are compiled first.
 */
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sacq_pkg::*;
   logic clk = 1'b0, rst_n = 1'b0, start = 1'b0, cont = 1'b0, ovr = 1'b0;
   logic enc, busy, sv, pv, enc_q = 1'b0;
   logic [11:0] val = 12'h0;
   sacq_dev_pins_t dev;
   sacq_sample_t smp, prv, last;
   int err_total = 0, compares = 0, cyc = 0, seed = 4473;
   int hi = 0, lo = 9, nrise = 0, k, npv = 0;
   always #10 clk = ~clk;
   sacq_host sacq_host_inst (.core_clk_i(clk), .rst_n_i(rst_n),
      .start_i(start), .continuous_i(cont), .dev_i(dev),
      .encode_strobe_o(enc), .busy_o(busy), .sample_valid_o(sv),
      .sample_o(smp), .prev_valid_o(pv), .prev_o(prv));
   sacq_dev_model sacq_dev_model_inst (.clk_i(clk), .rst_n_i(rst_n),
      .enc_i(enc), .val_i(val), .ovr_i(ovr), .pins_o(dev));
   task automatic chk(string nm, logic [24:0] seen, logic [24:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   function automatic sacq_sample_t exp_of(logic [11:0] v, logic o);
      return {v, ~v[11], v[10:0], o};
   endfunction
   always @(posedge clk) begin
      cyc++;
      if (cyc == 6000) begin
         err_total++;
         end_of_test();
      end
      enc_q <= enc;
      if (pv === 1'b1) begin
         npv <= npv + 1;
         chk("previous strobe", prv, last);
      end
      hi <= enc ? hi + 1 : 0;
      lo <= enc ? 0 : lo + 1;
      if (enc && !enc_q) begin
         nrise <= nrise + 1;
         chk("strobe low", 25'(lo >= LOW_MIN_CYC), 25'h1);
      end
      if (!enc && enc_q) begin
         chk("strobe high", 25'(hi >= HIGH_MIN_CYC && hi <= HIGH_MAX_CYC),
            25'h1);
      end
   end
   task automatic wait_sv();
      int n;
      n = 0;
      while (sv !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk("sample strobe", 25'(sv), 25'h1);
      chk("busy idle", 25'(busy), 25'h0);
   endtask
   task automatic conv(logic [11:0] v, logic o, int len);
      @(posedge clk);
      val <= v;
      ovr <= o;
      start <= 1'b1;
      repeat (len) @(posedge clk);
      start <= 1'b0;
      #1;
      chk("busy", 25'(busy), 25'h1);
      wait_sv();
      chk("sample", smp, exp_of(v, o));
      if (k > 0) chk("previous", prv, last);
      last = exp_of(v, o);
      k++;
   endtask
   initial begin
      k = 0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      conv(12'h000, 1'b1, 1);
      conv(12'hfff, 1'b0, 1);
      conv(12'h800, 1'b1, 1);
      conv(12'h7ff, 1'b0, 1);
      repeat (30) conv(12'($random(seed)), 1'($random(seed)), 1);
      nrise = 0;
      conv(12'h5a5, 1'b1, 3);
      chk("refused start", 25'(nrise), 25'h1);
      @(posedge clk);
      nrise = 0;
      cont <= 1'b1;
      repeat (20) @(posedge clk);
      cont <= 1'b0;
      chk("back to back", 25'(nrise >= 9), 25'h1);
      wait_sv();
      chk("last sample", smp, exp_of(12'h5a5, 1'b1));
      chk("previous count", 25'(npv), 25'(k));
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("reset strobes", 25'({enc, busy, sv, pv}), 25'h0);
      chk("reset sample", smp, 25'h0);
      chk("reset previous", prv, 25'h0);
      @(posedge clk);
      rst_n <= 1'b1;
      last = '0;
      conv(12'h3c3, 1'b0, 1);
      end_of_test();
   end
endmodule
`default_nettype wire
